// file: fps_regs.svh
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
// power-up timing, in nanoseconds, and clock period
`define FPS_CLK_PERIOD_NS     40
`define FPS_READ_DELAY_NS     70000
`define FPS_PROG_DELAY_NS     3000000
// read delay is a least time: round up
`define FPS_READ_DELAY_CYC    ((`FPS_READ_DELAY_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS)
// program delay is a longest time: round down
`define FPS_PROG_DELAY_CYC    (`FPS_PROG_DELAY_NS / `FPS_CLK_PERIOD_NS)
// address legend for the 264-byte page layout
`define FPS_ADDR_BITS         24
`define FPS_DUMMY_TOP_BITS    3
`define FPS_PAGE_BITS         12
`define FPS_BYTE_BITS         9
`define FPS_CNT_WIDTH         24
`endif

// file: fps_pkg.sv
package fps_pkg;
   typedef enum logic [3:0] {
      FPS_RESET   = 4'h1,
      FPS_WAIT    = 4'h2,
      FPS_STANDBY = 4'h4,
      FPS_ACTIVE  = 4'h8
   } fps_state_type;
   typedef enum logic [1:0] {
      FPS_DUMMY = 2'h0,
      FPS_PAGE  = 2'h1,
      FPS_BYTE  = 2'h2
   } fps_field_type;
   typedef enum logic {
      FPS_MODE0 = 1'b0,
      FPS_MODE3 = 1'b1
   } fps_spi_mode_type;
endpackage : fps_pkg

// file: fps_power_sequencer.sv
`timescale 1ns/1ps
`include "fps_regs.svh"
module fps_power_sequencer #(
   parameter int READ_DELAY_CYC = `FPS_READ_DELAY_CYC,
   parameter int PROG_DELAY_CYC = `FPS_PROG_DELAY_CYC
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   clk_en,
   // serial pins
   input  wire logic                   chip_select_n,
   input  wire logic                   sck,
   input  wire logic                   data_drive_req,
   input  wire logic                   data_drive_bit,
   output logic                        so_out,
   output logic                        so_oe,
   // address bit classification
   input  wire logic [4:0]             addr_bit_index,
   output fps_pkg::fps_field_type      addr_field,
   // sequencer status
   output fps_pkg::fps_state_type      state,
   output logic                        read_allowed,
   output logic                        prog_allowed,
   output logic                        cmd_accept,
   output fps_pkg::fps_spi_mode_type   spi_mode,
   output logic                        select_fall
);
   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   logic [2:0] cs_sync;
   logic [2:0] sck_sync;
   logic       cs_level;
   logic       sck_level;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_sync  <= 3'h7;
         sck_sync <= 3'h0;
      end else if (clk_en) begin
         cs_sync  <= {cs_sync[1:0], chip_select_n};
         sck_sync <= {sck_sync[1:0], sck};
      end
   end
   // accepted levels change only when stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_level  <= 1'b1;
         sck_level <= 1'b0;
      end else if (clk_en) begin
         if (cs_sync[1] == cs_sync[2]) cs_level <= cs_sync[2];
         if (sck_sync[1] == sck_sync[2]) sck_level <= sck_sync[2];
      end
   end
   logic cs_prev;
   logic cs_fall;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cs_prev <= 1'b1;
      else if (clk_en) cs_prev <= cs_level;
   end
   assign cs_fall = cs_prev && !cs_level;
   //------------------------------------------------------------------
   // select arming
   //------------------------------------------------------------------
   // the synchroniser resets to the idle high level, so a select already
   // low at reset release would look like a fall; only a high level that
   // really came through the pin after release may arm the detector
   logic live;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) live <= 1'b0;
      else if (clk_en) live <= 1'b1;
   end
   //------------------------------------------------------------------
   // power-up delay counters
   //------------------------------------------------------------------
   logic [`FPS_CNT_WIDTH-1:0] read_cnt;
   logic [`FPS_CNT_WIDTH-1:0] prog_cnt;
   logic                      read_done;
   logic                      prog_done;
   assign read_done = (read_cnt >= READ_DELAY_CYC[`FPS_CNT_WIDTH-1:0]);
   assign prog_done = (prog_cnt >= PROG_DELAY_CYC[`FPS_CNT_WIDTH-1:0]);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         read_cnt <= '0;
         prog_cnt <= '0;
      end else if (clk_en) begin
         if (!read_done) read_cnt <= read_cnt + 1'b1;
         if (!prog_done) prog_cnt <= prog_cnt + 1'b1;
      end
   end
   //------------------------------------------------------------------
   // state machine
   //------------------------------------------------------------------
   fps_pkg::fps_state_type next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         fps_pkg::FPS_RESET:   next_state = fps_pkg::FPS_WAIT;
         fps_pkg::FPS_WAIT: begin
            if (prog_done) begin
               next_state = cs_level ? fps_pkg::FPS_STANDBY
                                     : fps_pkg::FPS_ACTIVE;
            end
         end
         fps_pkg::FPS_STANDBY: if (!cs_level) next_state = fps_pkg::FPS_ACTIVE;
         fps_pkg::FPS_ACTIVE:  if (cs_level) next_state = fps_pkg::FPS_STANDBY;
         default:              next_state = fps_pkg::FPS_RESET;
      endcase
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) state <= fps_pkg::FPS_RESET;
      else if (clk_en) state <= next_state;
   end
   //------------------------------------------------------------------
   // transaction gating
   //------------------------------------------------------------------
   logic armed;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         armed        <= 1'b0;
         cmd_accept   <= 1'b0;
         spi_mode     <= fps_pkg::FPS_MODE0;
         select_fall  <= 1'b0;
         read_allowed <= 1'b0;
         prog_allowed <= 1'b0;
      end else if (clk_en) begin
         select_fall  <= cs_fall;
         read_allowed <= read_done;
         prog_allowed <= prog_done && (state != fps_pkg::FPS_RESET);
         if (live && (&cs_sync) && cs_level) armed <= 1'b1;
         if (cs_fall && armed && state != fps_pkg::FPS_RESET) begin
            cmd_accept <= 1'b1;
            spi_mode   <= fps_pkg::fps_spi_mode_type'(sck_level);
         end else if (cs_level) begin
            cmd_accept <= 1'b0;
         end
      end
   end
   //------------------------------------------------------------------
   // serial output driver
   //------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_oe  <= 1'b0;
         so_out <= 1'b0;
      end else if (clk_en) begin
         so_oe  <= cmd_accept && !cs_level && data_drive_req;
         so_out <= data_drive_bit;
      end
   end
   //------------------------------------------------------------------
   // address bit legend
   //------------------------------------------------------------------
   function automatic fps_pkg::fps_field_type classify(input logic [4:0] idx);
      if (idx < `FPS_DUMMY_TOP_BITS)
         classify = fps_pkg::FPS_DUMMY;
      else if (idx < `FPS_DUMMY_TOP_BITS + `FPS_PAGE_BITS)
         classify = fps_pkg::FPS_PAGE;
      else if (idx < `FPS_ADDR_BITS)
         classify = fps_pkg::FPS_BYTE;
      else
         classify = fps_pkg::FPS_DUMMY;
   endfunction : classify
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) addr_field <= fps_pkg::FPS_DUMMY;
      else if (clk_en) addr_field <= classify(addr_bit_index);
   end
   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence sel_fall_s;
      clk_en && cs_fall && armed && state != fps_pkg::FPS_RESET;
   endsequence
   sequence drive_req_s;
      clk_en && cmd_accept && !cs_level && data_drive_req;
   endsequence
   sequence wait_held_s;
      clk_en && state == fps_pkg::FPS_WAIT && !prog_done;
   endsequence
   hiz_idle_a: assert property (!cmd_accept |-> !so_oe)
      else $error("output driven without accepted command");
   accept_edge_a: assert property ($rose(cmd_accept) |-> $past(cs_fall))
      else $error("command accepted without select fall");
   mode_pick_a: assert property (sel_fall_s |=> spi_mode == $past(sck_level))
      else $error("mode not taken from clock idle level");
   read_gate_a: assert property (read_allowed |-> read_cnt >= READ_DELAY_CYC)
      else $error("read allowed before delay");
   reset_ignore_a: assert property (state == fps_pkg::FPS_RESET |=> !$rose(cmd_accept))
      else $error("command accepted in reset");
   prog_gate_a: assert property (prog_allowed |-> prog_cnt >= PROG_DELAY_CYC)
      else $error("program allowed before delay");
   wait_exit_a: assert property (clk_en && state == fps_pkg::FPS_WAIT && prog_done
      |=> state == ($past(cs_level) ? fps_pkg::FPS_STANDBY : fps_pkg::FPS_ACTIVE))
      else $error("wrong state after delay");
   field_map_a: assert property (clk_en && addr_bit_index < 5'(`FPS_DUMMY_TOP_BITS)
      |=> addr_field == fps_pkg::FPS_DUMMY)
      else $error("leading bits not dummy");
   so_drive_a: assert property (drive_req_s |=> so_oe && so_out == $past(data_drive_bit))
      else $error("output not driven on request");
   armed_only_a: assert property ($rose(cmd_accept) |-> $past(armed))
      else $error("command accepted before select seen high");
   fall_pulse_a: assert property (clk_en && select_fall |=> !select_fall)
      else $error("select fall pulse too long");
   reset_exit_a: assert property (clk_en && state == fps_pkg::FPS_RESET
      |=> state == fps_pkg::FPS_WAIT)
      else $error("reset state not left");
   wait_hold_a: assert property (wait_held_s |=> state == fps_pkg::FPS_WAIT)
      else $error("wait state left before delay");
   freeze_a: assert property (!clk_en |=> $stable(state) && $stable(cmd_accept))
      else $error("state moved while clock disabled");
endmodule : fps_power_sequencer

// file: fps_host_model.sv
`timescale 1ns/1ps
module fps_host_model (
   // clock and serial pins
   input  wire logic clk,
   output logic      chip_select_n,
   output logic      sck
);
   initial begin
      chip_select_n = 1'b1;
      sck           = 1'b0;
   end
   // clock parks at the idle level, then select falls
   task automatic begin_frame(input logic idle);
      @(negedge clk);
      sck = idle;
      repeat (3) @(negedge clk);
      chip_select_n = 1'b0;
   endtask : begin_frame
   // even number of toggles, 320 ns period, ends at idle
   task automatic end_frame();
      repeat (4) begin
         repeat (4) @(negedge clk);
         sck = ~sck;
      end
      repeat (4) @(negedge clk);
      chip_select_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask : end_frame
endmodule : fps_host_model

// file: fps_power_sequencer_bench.sv
`timescale 1ns/1ps
module fps_power_sequencer_bench;
   // ----------------------------------------
   // clock, reset and design
   // ----------------------------------------
   logic                      clk = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      en = 1'b1;
   logic                      drv_req = 1'b0;
   logic                      drv_bit = 1'b0;
   logic [4:0]                idx = 5'h00;
   logic                      cs_n, sck, so_out, so_oe, rd_ok, pg_ok, acc, fall;
   fps_pkg::fps_field_type    fld;
   fps_pkg::fps_state_type    st;
   fps_pkg::fps_spi_mode_type mode;
   int                        mismatches = 0;
   int                        cmp_count = 0;
   always #20 clk = ~clk;
   fps_host_model fps_host_model_inst (.clk(clk), .chip_select_n(cs_n), .sck(sck));
   fps_power_sequencer #(.READ_DELAY_CYC(20), .PROG_DELAY_CYC(50)) fps_power_sequencer_inst (
      .clk(clk), .arst_n(arst_n), .clk_en(en), .chip_select_n(cs_n), .sck(sck),
      .data_drive_req(drv_req), .data_drive_bit(drv_bit), .so_out(so_out), .so_oe(so_oe),
      .addr_bit_index(idx), .addr_field(fld), .state(st), .read_allowed(rd_ok),
      .prog_allowed(pg_ok), .cmd_accept(acc), .spi_mode(mode), .select_fall(fall));
   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      while (!(sel == 0 ? fall === 1'b1 : sel == 1 ? rd_ok === 1'b1 : pg_ok === 1'b1)
             && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n == lim) begin
         mismatches++;
         results();
      end
   endtask : wait_hi
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_phase();
      fps_host_model_inst.begin_frame(1'b1);
      check("state in reset", {28'h0, st}, {28'h0, fps_pkg::FPS_RESET});
      check("oe in reset", {31'h0, so_oe}, 32'h0);
      repeat (12 - 4) @(negedge clk);
      arst_n  = 1'b1;
      drv_req = 1'b1;
      repeat (10) @(negedge clk);
      check("accept without rise", {31'h0, acc}, 32'h0);
      check("oe not accepted", {31'h0, so_oe}, 32'h0);
      check("state waiting", {28'h0, st}, {28'h0, fps_pkg::FPS_WAIT});
      check("read early", {31'h0, rd_ok}, 32'h0);
      drv_req = 1'b0;
      fps_host_model_inst.end_frame();
   endtask : reset_phase
   task automatic frame_phase(input logic idle, input fps_pkg::fps_state_type exp_st);
      fps_host_model_inst.begin_frame(idle);
      wait_hi(0, 20);
      check("mode", {31'h0, mode}, {31'h0, idle});
      check("accept", {31'h0, acc}, 32'h1);
      @(negedge clk);
      check("state in frame", {28'h0, st}, {28'h0, exp_st});
      drv_req = 1'b1;
      drv_bit = ~idle;
      @(negedge clk);
      drv_req = 1'b0;
      check("oe driven", {31'h0, so_oe}, 32'h1);
      check("out bit", {31'h0, so_out}, {31'h0, ~idle});
      @(negedge clk);
      check("oe released", {31'h0, so_oe}, 32'h0);
      fps_host_model_inst.end_frame();
      check("accept ends", {31'h0, acc}, 32'h0);
   endtask : frame_phase
   task automatic addr_phase();
      for (int i = 0; i < 24; i++) begin
         idx = 5'(i);
         @(negedge clk);
         check("field", {30'h0, fld}, i < 3 ? 32'h0 : i < 15 ? 32'h1 : 32'h2);
      end
   endtask : addr_phase
   task automatic hold_phase();
      en  = 1'b0;
      idx = 5'h00;
      repeat (3) @(negedge clk);
      check("field frozen", {30'h0, fld}, 32'h2);
      check("state frozen", {28'h0, st}, {28'h0, fps_pkg::FPS_STANDBY});
      en = 1'b1;
      @(negedge clk);
      check("field resumed", {30'h0, fld}, 32'h0);
   endtask : hold_phase
   task automatic reset_again();
      arst_n = 1'b0;
      @(negedge clk);
      check("state in reset again", {28'h0, st}, {28'h0, fps_pkg::FPS_RESET});
      check("oe in reset again", {31'h0, so_oe}, 32'h0);
      check("accept in reset again", {31'h0, acc}, 32'h0);
      check("read in reset again", {31'h0, rd_ok}, 32'h0);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      check("state after reset again", {28'h0, st}, {28'h0, fps_pkg::FPS_WAIT});
      check("oe after reset again", {31'h0, so_oe}, 32'h0);
      check("read after reset again", {31'h0, rd_ok}, 32'h0);
   endtask : reset_again
   initial begin
      reset_phase();
      wait_hi(1, 40);
      check("prog early", {31'h0, pg_ok}, 32'h0);
      frame_phase(1'b1, fps_pkg::FPS_WAIT);
      wait_hi(2, 80);
      check("standby", {28'h0, st}, {28'h0, fps_pkg::FPS_STANDBY});
      frame_phase(1'b0, fps_pkg::FPS_ACTIVE);
      addr_phase();
      hold_phase();
      reset_again();
      results();
   end
endmodule : fps_power_sequencer_bench
